// >>> src/hzc_params.svh
// Register offsets, field positions and reset values of the shutdown block
`ifndef HZC_PARAMS_SVH
`define HZC_PARAMS_SVH

`define HZC_OFS_CTRL        4'h0
`define HZC_OFS_SEL         4'h4
`define HZC_OFS_IRQ_STAT    4'h8
`define HZC_OFS_IRQ_MASK    4'hc

`define HZC_CTRL_ENABLE     7
`define HZC_CTRL_REL_COND   6
`define HZC_CTRL_FALL       5
`define HZC_CTRL_RISE       4
`define HZC_CTRL_FORCE      3
`define HZC_CTRL_RELEASE    2
`define HZC_CTRL_FLAG       0

`define HZC_SEL_PINS_LSB    0
`define HZC_SEL_PINS_MSB    3
`define HZC_SEL_SRC_LSB     6
`define HZC_SEL_SRC_MSB     7
`define HZC_SEL_TRIG_EN     8

`define HZC_IRQ_ENTER       0
`define HZC_IRQ_RELEASE     1

`define HZC_RST_CTRL        8'h00
`define HZC_RST_SEL         9'h000
`define HZC_RST_IRQ         2'h0

`endif

// >>> src/hzc_pkg.sv
// Types shared by the shutdown block modules
package hzc_pkg;

    typedef enum logic [1:0]
    {
        HZC_SRC_EXT  = 2'b00,
        HZC_SRC_CMP0 = 2'b01,
        HZC_SRC_CMP1 = 2'b10,
        HZC_SRC_CMP2 = 2'b11
    } hzc_src_t;

    typedef enum logic [1:0]
    {
        HZC_EDGE_NONE = 2'b00,
        HZC_EDGE_RISE = 2'b01,
        HZC_EDGE_FALL = 2'b10,
        HZC_EDGE_BAD  = 2'b11
    } hzc_edge_t;

endpackage

// >>> src/hzc_trig_if.sv
// Carrier between register core and trigger detector
`timescale 1ns/10ps
`default_nettype none

interface hzc_trig_if;
    hzc_pkg::hzc_src_t  src;
    hzc_pkg::hzc_edge_t edge_sel;
    logic               trig_en;
    logic               ctl_en;
    logic               edge_det;
    logic               trig_active;

    modport core
    (
        output src,
        output edge_sel,
        output trig_en,
        output ctl_en,
        input  edge_det,
        input  trig_active
    );

    modport det
    (
        input  src,
        input  edge_sel,
        input  trig_en,
        input  ctl_en,
        output edge_det,
        output trig_active
    );
endinterface

`default_nettype wire

// >>> src/hzc_trigger.sv
// Trigger source select and valid edge detector
`timescale 1ns/10ps
`default_nettype none

module hzc_trigger
(
    // Clock and synchronised reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Trigger sources
    input  wire logic       i_ext_interrupt_input,
    input  wire logic [2:0] i_cmp_out,
    // Core side
    hzc_trig_if.det         trig
);

    logic level;
    logic prev_q;
    logic prev_d;

    always_comb
    begin
        case (trig.src)
            hzc_pkg::HZC_SRC_EXT:  level = i_ext_interrupt_input;
            hzc_pkg::HZC_SRC_CMP0: level = i_cmp_out[0];
            hzc_pkg::HZC_SRC_CMP1: level = i_cmp_out[1];
            hzc_pkg::HZC_SRC_CMP2: level = i_cmp_out[2];
            default:               level = 1'b0;
        endcase
        if (!trig.trig_en)
        begin
            level = 1'b0;
        end
        prev_d = level;
        // Level history runs while disabled, so a trigger already active at enable gives no edge
        trig.edge_det = 1'b0;
        trig.trig_active = 1'b0;
        case (trig.edge_sel)
            hzc_pkg::HZC_EDGE_RISE:
            begin
                trig.edge_det    = trig.ctl_en & level & ~prev_q;
                trig.trig_active = level;
            end
            hzc_pkg::HZC_EDGE_FALL:
            begin
                trig.edge_det    = trig.ctl_en & ~level & prev_q;
                trig.trig_active = trig.trig_en & ~level;
            end
            default:
            begin
                trig.edge_det    = 1'b0;
                trig.trig_active = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
        end
    end

endmodule

`default_nettype wire

// >>> src/hzc_top.sv
// Output high-impedance shutdown control with Avalon-MM registers
//
// Function
// - Release condition 1: clear releases only while the trigger is inactive.
// - Release condition 0: clear always releases, whatever the trigger level.
// - Under release condition 0, a clear landing with a valid edge in one cycle wins over the edge.
// - With no edge selected, one force command enters high impedance and sets the flag.
// - Two-bit source: external interrupt input, or comparator 0, 1 or 2.
// - Two-bit edge code: none, rising, falling; code 11 prohibited.
// - Only edges seen after control is enabled cause shutdown.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "hzc_params.svh"

module hzc_top
#(
    parameter int NPINS = 4
)
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]       i_address,
    input  wire logic             i_read,
    input  wire logic             i_write,
    input  wire logic [31:0]      i_writedata,
    input  wire logic [3:0]       i_byteenable,
    output logic      [31:0]      o_readdata,
    output logic                  o_waitrequest,
    // Trigger sources
    input  wire logic             i_ext_interrupt_input,
    input  wire logic [2:0]       i_cmp_out,
    // Timer pin drive in and out
    input  wire logic [NPINS-1:0] i_pin_out,
    input  wire logic [NPINS-1:0] i_pin_oe,
    output logic      [NPINS-1:0] o_pin_out,
    output logic      [NPINS-1:0] o_pin_oe,
    // Status
    output logic                  o_hiz_state_flag,
    output logic                  o_irq
);

    hzc_trig_if trig ();

    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Register state
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_d;
    logic [8:0]       sel_q;
    logic [8:0]       sel_d;
    logic             flag_q;
    logic             flag_d;
    logic [1:0]       irq_stat_q;
    logic [1:0]       irq_stat_d;
    logic [1:0]       irq_mask_q;
    logic [1:0]       irq_mask_d;
    logic             wait_q;
    logic             wait_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic [NPINS-1:0] pin_out_q;
    logic [NPINS-1:0] pin_out_d;
    logic [NPINS-1:0] pin_oe_q;
    logic [NPINS-1:0] pin_oe_d;
    logic             irq_q;
    logic             irq_d;

    // Bus decode
    logic       req;
    logic       wr_go;
    logic       wr_ctrl;
    logic       force_cmd;
    logic       release_cmd;
    logic       release_ok;
    logic       flag_set;
    logic       flag_clr;
    logic [1:0] w1c;
    logic [3:0] pin_sel;

    assign trig.src      = hzc_pkg::hzc_src_t'(sel_q[`HZC_SEL_SRC_MSB:`HZC_SEL_SRC_LSB]);
    assign trig.edge_sel = hzc_pkg::hzc_edge_t'({ctrl_q[`HZC_CTRL_FALL], ctrl_q[`HZC_CTRL_RISE]});
    assign trig.trig_en  = sel_q[`HZC_SEL_TRIG_EN];
    assign trig.ctl_en   = ctrl_q[`HZC_CTRL_ENABLE];
    assign pin_sel       = sel_q[`HZC_SEL_PINS_MSB:`HZC_SEL_PINS_LSB];

    hzc_trigger u_trigger
    (
        .i_clk                 (i_clk),
        .i_rst_n               (rst_sync_q),
        .i_ext_interrupt_input (i_ext_interrupt_input),
        .i_cmp_out             (i_cmp_out),
        .trig                  (trig)
    );

    // One wait cycle on every access
    always_comb
    begin
        req    = i_read | i_write;
        wait_d = ~(req & wait_q);
        wr_go  = i_write & ~wait_q & i_byteenable[0];
        rdata_d = rdata_q;
        if (req && wait_q)
        begin
            case (i_address)
                `HZC_OFS_CTRL:     rdata_d = {24'h000000, ctrl_q[7:4], 3'h0, flag_q};
                `HZC_OFS_SEL:      rdata_d = {23'h000000, sel_q};
                `HZC_OFS_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
                `HZC_OFS_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
                default:           rdata_d = 32'h00000000;
            endcase
        end
    end

    // Control, selection and mask
    always_comb
    begin
        wr_ctrl     = wr_go && (i_address == `HZC_OFS_CTRL);
        ctrl_d      = ctrl_q;
        sel_d       = sel_q;
        irq_mask_d  = irq_mask_q;
        if (wr_ctrl)
        begin
            // Command bits are strobes and never stored
            ctrl_d = {i_writedata[7:4], 4'h0};
        end
        if (wr_go && (i_address == `HZC_OFS_SEL))
        begin
            sel_d = i_writedata[8:0];
        end
        if (wr_go && (i_address == `HZC_OFS_IRQ_MASK))
        begin
            irq_mask_d = i_writedata[1:0];
        end
    end

    // Commands and state flag
    always_comb
    begin
        // Commands only act while control is enabled
        force_cmd   = wr_ctrl & ctrl_q[`HZC_CTRL_ENABLE] & i_writedata[`HZC_CTRL_FORCE];
        release_cmd = wr_ctrl & ctrl_q[`HZC_CTRL_ENABLE] & i_writedata[`HZC_CTRL_RELEASE];
        release_ok  = release_cmd & (~ctrl_q[`HZC_CTRL_REL_COND]
                                     | ~trig.trig_active);
        flag_set    = force_cmd | trig.edge_det;
        // Clear is weighed first, so it beats a coinciding edge or force
        flag_clr    = release_ok;
        flag_d      = flag_q;
        // Dropping the enable clears the flag with that same write
        if (!ctrl_d[`HZC_CTRL_ENABLE])
        begin
            flag_d = 1'b0;
        end
        else if (flag_clr)
        begin
            flag_d = 1'b0;
        end
        else if (flag_set)
        begin
            flag_d = 1'b1;
        end
    end

    // Pin drive copies
    always_comb
    begin
        // Selected pins float one cycle after the flag
        for (int i = 0; i < NPINS; i++)
        begin
            pin_oe_d[i] = i_pin_oe[i] & ~(flag_q & ((i < 4) ? pin_sel[i % 4] : 1'b0));
        end
        pin_out_d = i_pin_out;
    end

    // Interrupt status and line
    always_comb
    begin
        w1c = 2'h0;
        if (wr_go && (i_address == `HZC_OFS_IRQ_STAT))
        begin
            w1c = i_writedata[1:0];
        end
        irq_stat_d = irq_stat_q & ~w1c;
        if (flag_d && !flag_q)
        begin
            irq_stat_d[`HZC_IRQ_ENTER] = 1'b1;
        end
        if (!flag_d && flag_q)
        begin
            irq_stat_d[`HZC_IRQ_RELEASE] = 1'b1;
        end
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    // Bus answer: waitrequest idles high
    always_ff @(posedge i_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Control, selection and mask registers
    always_ff @(posedge i_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ctrl_q     <= `HZC_RST_CTRL;
            sel_q      <= `HZC_RST_SEL;
            irq_mask_q <= `HZC_RST_IRQ;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            sel_q      <= sel_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // State flag
    always_ff @(posedge i_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    // Interrupt status and line
    always_ff @(posedge i_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            irq_stat_q <= `HZC_RST_IRQ;
            irq_q      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_q      <= irq_d;
        end
    end

    // Pin drive copies
    always_ff @(posedge i_clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end

    assign o_readdata       = rdata_q;
    assign o_waitrequest    = wait_q;
    assign o_pin_out        = pin_out_q;
    assign o_pin_oe         = pin_oe_q;
    assign o_hiz_state_flag = flag_q;
    assign o_irq            = irq_q;

endmodule

`default_nettype wire

// >>> testbench/hzc_fault_model.sv
// Far side: fault trigger sources and normal timer pin drive
`timescale 1ns/10ps
`default_nettype none
module hzc_fault_model
(
    // Clock and requested levels
    input  wire logic       i_clk,
    input  wire logic [3:0] i_lvl,
    // Trigger sources and timer drive
    output logic            o_ext,
    output logic      [2:0] o_cmp,
    output logic      [3:0] o_pin_out,
    output logic      [3:0] o_pin_oe
);
    logic [3:0] lvl_q = 4'h0;
    logic       tog_q = 1'b0;
    // Levels move only at edges; pin data toggles every cycle
    always @(posedge i_clk)
    begin
        lvl_q <= i_lvl;
        tog_q <= ~tog_q;
    end
    assign o_ext     = lvl_q[0];
    assign o_cmp     = lvl_q[3:1];
    assign o_pin_out = {tog_q, ~tog_q, tog_q, ~tog_q};
    assign o_pin_oe  = 4'hf;
endmodule
`default_nettype wire

// >>> testbench/hzc_asserts.sv
// Port-level assertions for the shutdown block
`timescale 1ns/10ps
`default_nettype none
module hzc_asserts
#(
    parameter int NPINS = 4
)
(
    // Clock and reset
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    // Bus
    input wire logic [3:0]       i_address,
    input wire logic             i_read,
    input wire logic             i_write,
    input wire logic [31:0]      i_writedata,
    input wire logic [3:0]       i_byteenable,
    input wire logic [31:0]      o_readdata,
    input wire logic             o_waitrequest,
    // Pins and status
    input wire logic [NPINS-1:0] i_pin_oe,
    input wire logic [NPINS-1:0] o_pin_oe,
    input wire logic             o_hiz_state_flag,
    input wire logic             o_irq
);
    logic [2:0]       up_q;
    logic             en_q;
    logic [NPINS-1:0] pins_q;
    logic             wa;
    logic             wc;
    assign wa = i_write && !o_waitrequest && i_byteenable[0];
    assign wc = wa && i_address == 4'h0;
    // Live once the internal reset copy has let go
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            up_q <= 3'h0;
            en_q <= 1'b0;
            pins_q <= '0;
        end
        else
        begin
            up_q <= {up_q[1:0], 1'b1};
            if (wc)
                en_q <= i_writedata[7];
            if (wa && i_address == 4'h4)
                pins_q <= i_writedata[NPINS-1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!up_q[2]);
    a_wait_one: assert property ($rose(i_read | i_write) |=> !o_waitrequest) else $error("late bus answer");
    a_wait_idle: assert property (!(i_read | i_write) |-> o_waitrequest) else $error("idle answer");
    a_oe_normal: assert property
        (!$past(o_hiz_state_flag) |-> o_pin_oe == $past(i_pin_oe)) else $error("pin drive altered");
    a_oe_float: assert property
        ($past(o_hiz_state_flag) |-> (o_pin_oe & $past(pins_q)) == '0) else $error("target pin driven");
    a_dis_clears: assert property (wc && !i_writedata[7] |=> !o_hiz_state_flag) else $error("flag kept");
    a_rel_any: assert property
        (wc && i_writedata[7:6] == 2'h2 && i_writedata[2] |=> !o_hiz_state_flag) else $error("release lost");
    a_force_none: assert property
        (wc && en_q && i_writedata[7] && i_writedata[5:2] == 4'h2 |=> o_hiz_state_flag) else $error("force lost");
    a_cmd_reads0: assert property
        (i_read && !o_waitrequest && i_address == 4'h0 |-> o_readdata[3:1] == 3'h0) else $error("command reads 1");
    c_enter: cover property ($rose(o_hiz_state_flag));
    c_irq: cover property (o_irq);
    c_release: cover property (wc && i_writedata[2] && o_hiz_state_flag);
endmodule
bind hzc_top hzc_asserts #(.NPINS(NPINS)) u_chk
(
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_pin_oe(i_pin_oe), .o_pin_oe(o_pin_oe),
    .o_hiz_state_flag(o_hiz_state_flag), .o_irq(o_irq)
);
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the shutdown block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [3:0]  lvl = 4'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        wreq;
    logic        ext;
    logic [2:0]  cmp;
    logic [3:0]  p_out;
    logic [3:0]  p_oe;
    logic [3:0]  pout;
    logic [3:0]  oe;
    logic        flag;
    logic        irq;
    int          n_fail = 0;
    int          n_checks = 0;
    always #12.5 i_clk = ~i_clk;
    hzc_fault_model u_far (.i_clk(i_clk), .i_lvl(lvl), .o_ext(ext), .o_cmp(cmp), .o_pin_out(p_out), .o_pin_oe(p_oe));
    hzc_top #(.NPINS(4)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(adr), .i_read(rd_en), .i_write(wr_en),
        .i_writedata(wdat), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wreq), .i_ext_interrupt_input(ext),
        .i_cmp_out(cmp), .i_pin_out(p_out), .i_pin_oe(p_oe), .o_pin_out(pout), .o_pin_oe(oe), .o_hiz_state_flag(flag),
        .o_irq(irq));
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        be <= b;
        wr_en <= w;
        rd_en <= !w;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        rd = rdat;
        if (n >= 20)
        begin
            n_fail++;
            give_verdict();
        end
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask
    task automatic st;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic fl(input logic e);
        int n;
        n = 0;
        while (flag !== e && n < 10)
        begin
            @(posedge i_clk);
            n++;
        end
        chk({31'h0, flag}, {31'h0, e});
    endtask
    task automatic t_force;
        rc(4'h0, 32'h0);
        rc(4'h2, 32'h0);
        wr(4'h4, 32'h105);
        wr(4'h0, 32'h80);
        wr(4'h0, 32'h88);
        fl(1'b1);
        rc(4'h0, 32'h81);
        chk({28'h0, oe}, 32'ha);
        chk({28'h0, pout}, {28'h0, ~p_out});
        rc(4'h8, 32'h1);
        wr(4'hc, 32'h1);
        st;
        chk({31'h0, irq}, 32'h1);
        wr(4'h8, 32'h1);
        st;
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 4'h0, 32'h0, 4'h0);
        st;
        fl(1'b1);
        wr(4'h0, 32'h0);
        fl(1'b0);
    endtask
    task automatic t_rel;
        wr(4'h0, 32'h10);
        wr(4'h0, 32'h90);
        lvl <= 4'h1;
        fl(1'b1);
        wr(4'h0, 32'h94);
        fl(1'b0);
        wr(4'h0, 32'h0);
        wr(4'h0, 32'h50);
        wr(4'h0, 32'hd0);
        st;
        fl(1'b0);
        lvl <= 4'h0;
        st;
        lvl <= 4'h1;
        fl(1'b1);
        wr(4'h0, 32'hd4);
        rc(4'h0, 32'hd1);
        lvl <= 4'h0;
        st;
        wr(4'h0, 32'hd4);
        rc(4'h0, 32'hd0);
        wr(4'h0, 32'hd8);
        rc(4'h0, 32'hd1);
        wr(4'h0, 32'hd4);
        rc(4'h0, 32'hd0);
    endtask
    task automatic t_cmp;
        for (int s = 1; s < 4; s++)
        begin
            wr(4'h0, 32'h0);
            wr(4'h4, 32'h5);
            lvl <= 4'he;
            st;
            wr(4'h0, 32'h20);
            wr(4'h4, 32'h105 | (s << 6));
            wr(4'h0, 32'ha0);
            lvl <= 4'he & ~(4'h1 << (s % 3 + 1));
            st;
            fl(1'b0);
            lvl <= 4'he & ~(4'h1 << (s % 3 + 1)) & ~(4'h1 << s);
            fl(1'b1);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_force;
        t_rel;
        t_cmp;
        give_verdict();
    end
endmodule
`default_nettype wire
